// [src/wdog_pkg.sv]
// Constants, types and field layout for the system watchdog timer
// Behaviour
// - An active watchdog left unserviced past its timeout enters the timed-out condition.
// - Timeout drives either the low timeout line or the low reset line, by software choice.
// - Once enabled the watchdog stays enabled; writes clearing the enable are ignored.
// - Counting pauses separately in deep or light sleep and in core idle.
// - Some configuration bits take only the first write after reset.
// - One instance can also raise an interrupt toward the processor.
// - Servicing before timeout restarts the interval from its full programmed value.
package wdog_pkg;
  localparam int CLK_NS   = 20;
  localparam int TICK_NS  = 1000;
  localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W  = 16;

  localparam logic [ADDR_W-1:0] OFS_CTRL    = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_TIMEOUT = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_SERVICE = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_COUNT   = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_MASK    = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_WARN    = 8'h18;

  localparam int CTRL_EN_BIT  = 0;
  localparam int CTRL_CFG_LSB = 1;
  localparam int CTRL_LCK_BIT = 4;
  localparam int CFG_W        = 3;

  localparam int STAT_EXP_BIT  = 0;
  localparam int STAT_WARN_BIT = 1;
  localparam int STAT_RUN_BIT  = 2;
  localparam int STAT_W        = 2;

  localparam logic [DATA_W-1:0] SERVICE_KEY = 32'h0000_5a3c;
  localparam logic [CNT_W-1:0]  TIMEOUT_RST = 16'h03e8;
  localparam logic [CNT_W-1:0]  WARN_RST    = 16'h0064;
  localparam logic [STAT_W-1:0] MASK_RST    = 2'h0;
  localparam logic [CFG_W-1:0]  CFG_RST     = 3'h0;

  typedef struct packed {
    logic suspIdle;
    logic suspSleep;
    logic rstSel;
  } cfg_s;

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_EXPIRED} wd_state_e;
endpackage : wdog_pkg

// [src/tick_divider.sv]
// Divider producing a one-cycle tick enable
`timescale 1ns/1ps
module tick_divider #(
  parameter int DIV = 50
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic run,
  output logic      tick
);
  localparam int CW = $clog2(DIV + 1);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } div_s;

  div_s s_r;
  div_s s_nxt;

  always_comb
  begin
    s_nxt      = s_r;
    s_nxt.tick = 1'b0;
    if (!run)
    begin
      s_nxt.cnt = '0;
    end
    else if (s_r.cnt == LAST)
    begin
      s_nxt.cnt  = '0;
      s_nxt.tick = 1'b1;
    end
    else
    begin
      s_nxt.cnt = s_r.cnt + CW'(1);
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign tick = s_r.tick;
endmodule : tick_divider

// [src/write_once_reg.sv]
// Register that accepts only its first write after reset
`timescale 1ns/1ps
module write_once_reg #(
  parameter int              W   = 3,
  parameter logic [W-1:0]    RST = '0
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         wrEn,
  input  wire logic [W-1:0] wrData,
  output logic      [W-1:0] q,
  output logic              locked
);
  typedef struct packed {
    logic         locked;
    logic [W-1:0] val;
  } wo_s;

  wo_s s_r;
  wo_s s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    if (wrEn && !s_r.locked)
    begin
      s_nxt.val    = wrData;
      s_nxt.locked = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      s_r <= '{locked: 1'b0, val: RST};
    else
      s_r <= s_nxt;
  end

  assign q      = s_r.val;
  assign locked = s_r.locked;
endmodule : write_once_reg

// [src/system_watchdog_timer.sv]
// Watchdog timer with classic Wishbone register access
`timescale 1ns/1ps
module system_watchdog_timer #(
  parameter int CNT_W    = wdog_pkg::CNT_W,
  parameter int TICK_DIV = wdog_pkg::TICK_CYC,
  parameter bit HAS_IRQ  = 1'b1
) (
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [wdog_pkg::ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                  wb_sel_i,
  input  wire logic [wdog_pkg::DATA_W-1:0] wb_dat_i,
  output logic      [wdog_pkg::DATA_W-1:0] wb_dat_o,
  output logic                             wb_ack_o,
  input  wire logic                        deepSleep,
  input  wire logic                        lightSleepMode,
  input  wire logic                        coreIdle,
  output logic                             timeoutN,
  output logic                             sysResetN,
  output logic                             irq
);
  localparam int DW = wdog_pkg::DATA_W;
  localparam int SW = wdog_pkg::STAT_W;

  typedef struct packed {
    wdog_pkg::wd_state_e state;
    logic                en;
    logic [CNT_W-1:0]    count;
    logic [CNT_W-1:0]    timeout;
    logic [CNT_W-1:0]    warn;
    logic [SW-1:0]       status;
    logic [SW-1:0]       mask;
    logic                ack;
    logic [DW-1:0]       dat;
    logic                timeoutN;
    logic                sysResetN;
    logic                irq;
  } top_s;

  top_s                s_r;
  top_s                s_nxt;
  wdog_pkg::cfg_s      cfg;
  logic                cfgLocked;
  logic                cfgWr;
  logic                tick;

  // Byte-lane merge of a write into a narrower register
  function automatic logic [DW-1:0] laneMerge(
    input logic [DW-1:0] oldVal,
    input logic [DW-1:0] newVal,
    input logic [3:0]    sel
  );
    logic [DW-1:0] res;
    res = oldVal;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
        res[b*8 +: 8] = newVal[b*8 +: 8];
    end
    return res;
  endfunction : laneMerge

  tick_divider #(
    .DIV (TICK_DIV)
  ) u_div (
    .clk     (clk),
    .sys_rst (sys_rst),
    .run     (s_r.state == wdog_pkg::ST_RUN),
    .tick    (tick)
  );

  write_once_reg #(
    .W   (wdog_pkg::CFG_W),
    .RST (wdog_pkg::CFG_RST)
  ) u_cfg (
    .clk     (clk),
    .sys_rst (sys_rst),
    .wrEn    (cfgWr),
    .wrData  (wb_dat_i[wdog_pkg::CTRL_CFG_LSB +: wdog_pkg::CFG_W]),
    .q       (cfg),
    .locked  (cfgLocked)
  );

  logic          acc;
  logic          wr;
  logic [7:0]    adr;
  logic          serviceHit;
  logic          suspended;
  logic [SW-1:0] setBits;
  logic [SW-1:0] clrBits;
  logic [CNT_W-1:0] nextCount;

  assign acc   = wb_cyc_i && wb_stb_i && !s_r.ack;
  assign wr    = acc && wb_we_i;
  assign adr   = {wb_adr_i[wdog_pkg::ADDR_W-1:2], 2'b00};
  assign cfgWr = wr && (adr == wdog_pkg::OFS_CTRL) && wb_sel_i[0];

  always_comb
  begin
    s_nxt      = s_r;
    s_nxt.ack  = 1'b0;
    s_nxt.dat  = '0;
    setBits    = '0;
    clrBits    = '0;
    nextCount  = s_r.count - CNT_W'(1);
    serviceHit = wr && (adr == wdog_pkg::OFS_SERVICE) && (wb_dat_i == wdog_pkg::SERVICE_KEY);
    suspended  = (cfg.suspSleep && (deepSleep || lightSleepMode))
                 || (cfg.suspIdle && coreIdle);

    if (acc)
    begin
      s_nxt.ack = 1'b1;
      if (!wb_we_i)
      begin
        unique case (adr)
          wdog_pkg::OFS_CTRL:
          begin
            s_nxt.dat[wdog_pkg::CTRL_EN_BIT] = s_r.en;
            s_nxt.dat[wdog_pkg::CTRL_CFG_LSB +: wdog_pkg::CFG_W] = cfg;
            s_nxt.dat[wdog_pkg::CTRL_LCK_BIT] = cfgLocked;
          end
          wdog_pkg::OFS_TIMEOUT: s_nxt.dat = DW'(s_r.timeout);
          wdog_pkg::OFS_COUNT:   s_nxt.dat = DW'(s_r.count);
          wdog_pkg::OFS_WARN:    s_nxt.dat = DW'(s_r.warn);
          wdog_pkg::OFS_MASK:    s_nxt.dat[SW-1:0] = s_r.mask;
          wdog_pkg::OFS_STATUS:
          begin
            s_nxt.dat[SW-1:0] = s_r.status;
            s_nxt.dat[wdog_pkg::STAT_RUN_BIT] = (s_r.state == wdog_pkg::ST_RUN);
          end
          default:               s_nxt.dat = '0;
        endcase
      end
      else
      begin
        unique case (adr)
          wdog_pkg::OFS_CTRL:
          begin
            if (wb_sel_i[0] && wb_dat_i[wdog_pkg::CTRL_EN_BIT])
              s_nxt.en = 1'b1;
          end
          wdog_pkg::OFS_TIMEOUT:
            s_nxt.timeout = CNT_W'(laneMerge(DW'(s_r.timeout), wb_dat_i, wb_sel_i));
          wdog_pkg::OFS_WARN:
            s_nxt.warn = CNT_W'(laneMerge(DW'(s_r.warn), wb_dat_i, wb_sel_i));
          wdog_pkg::OFS_MASK:
          begin
            if (wb_sel_i[0])
              s_nxt.mask = wb_dat_i[SW-1:0];
          end
          wdog_pkg::OFS_STATUS:
          begin
            if (wb_sel_i[0])
              clrBits = wb_dat_i[SW-1:0];
          end
          default:
          begin
          end
        endcase
      end
    end

    unique case (s_r.state)
      wdog_pkg::ST_IDLE:
      begin
        s_nxt.count = '0;
        if (s_r.en)
        begin
          s_nxt.count = s_r.timeout;
          s_nxt.state = wdog_pkg::ST_RUN;
        end
      end
      wdog_pkg::ST_RUN:
      begin
        if (serviceHit)
          s_nxt.count = s_r.timeout;
        else if (tick && !suspended)
        begin
          if (s_r.count == '0)
          begin
            s_nxt.state = wdog_pkg::ST_EXPIRED;
            setBits[wdog_pkg::STAT_EXP_BIT] = 1'b1;
            if (cfg.rstSel)
              s_nxt.sysResetN = 1'b0;
            else
              s_nxt.timeoutN = 1'b0;
          end
          else
          begin
            s_nxt.count = nextCount;
            if (nextCount == s_r.warn)
              setBits[wdog_pkg::STAT_WARN_BIT] = 1'b1;
          end
        end
      end
      wdog_pkg::ST_EXPIRED:
      begin
        s_nxt.count = '0;
      end
      default:
      begin
        s_nxt.state = wdog_pkg::ST_IDLE;
      end
    endcase

    s_nxt.status = (s_r.status & ~clrBits) | setBits;
    s_nxt.irq    = HAS_IRQ && |(s_nxt.status & s_nxt.mask);
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_r           <= '0;
      s_r.state     <= wdog_pkg::ST_IDLE;
      s_r.timeout   <= CNT_W'(wdog_pkg::TIMEOUT_RST);
      s_r.warn      <= CNT_W'(wdog_pkg::WARN_RST);
      s_r.mask      <= wdog_pkg::MASK_RST;
      s_r.timeoutN  <= 1'b1;
      s_r.sysResetN <= 1'b1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign wb_dat_o  = s_r.dat;
  assign wb_ack_o  = s_r.ack;
  assign timeoutN  = s_r.timeoutN;
  assign sysResetN = s_r.sysResetN;
  assign irq       = s_r.irq;
endmodule : system_watchdog_timer

// [sim/wdog_props.sv]
// Port checker for the watchdog timer
`timescale 1ns/1ps
module wdog_props (
  input wire logic                        clk,
  input wire logic                        sys_rst,
  input wire logic                        wb_cyc_i,
  input wire logic                        wb_stb_i,
  input wire logic                        wb_we_i,
  input wire logic [wdog_pkg::DATA_W-1:0] wb_dat_o,
  input wire logic                        wb_ack_o,
  input wire logic                        timeoutN,
  input wire logic                        sysResetN,
  input wire logic                        irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  sequence take_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  ack_time_a: assert property (take_s |=> wb_ack_o) else $error("ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_cause_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("stray ack");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == '0) else $error("data off ack");
  tout_hold_a: assert property (!timeoutN |=> !timeoutN) else $error("timeout left");
  rst_hold_a: assert property (!sysResetN |=> !sysResetN) else $error("reset left");
  one_out_a: assert property (timeoutN || sysResetN) else $error("both low");
  irq_clear_a: assert property ($fell(irq) |-> wb_ack_o && $past(wb_we_i))
    else $error("irq fell alone");
endmodule : wdog_props

bind system_watchdog_timer wdog_props chk_u (.clk(clk), .sys_rst(sys_rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .timeoutN(timeoutN), .sysResetN(sysResetN), .irq(irq));

// [sim/system_watchdog_timer_tb.sv]
// Self-checking bench for the watchdog timer
`timescale 1ns/1ps
module system_watchdog_timer_tb;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rd;
  logic [31:0] rdat;
  logic        ack;
  logic        toutN;
  logic        rstN;
  logic        irq;
  logic        deep = 1'b0;
  logic        light = 1'b0;
  logic        idle = 1'b0;
  int          nFail = 0;
  int          totalChecks = 0;

  always #10 clk = ~clk;

  system_watchdog_timer #(.TICK_DIV(2)) dut_u (.clk(clk), .sys_rst(sys_rst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(rd), .wb_ack_o(ack), .deepSleep(deep),
    .lightSleepMode(light), .coreIdle(idle), .timeoutN(toutN), .sysResetN(rstN), .irq(irq));

  task automatic give_verdict();
    $display("checks %0d failures %0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp)
    begin
      nFail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One classic cycle, waits for ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    rdat = rd;
    if (ack !== 1'b1)
    begin
      nFail++;
      give_verdict();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask : wb

  task automatic waitOut();
    int n;
    n = 0;
    while (toutN === 1'b1 && rstN === 1'b1 && n < 40)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 40)
    begin
      nFail++;
      give_verdict();
    end
  endtask : waitOut

  task automatic doReset();
    sys_rst <= 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
  endtask : doReset

  task automatic t_idle();
    wb(1'b1, wdog_pkg::OFS_SERVICE, wdog_pkg::SERVICE_KEY);
    repeat (30) @(posedge clk);
    chk(toutN, 1'b1);
    chk(rstN, 1'b1);
    chk(irq, 1'b0);
    wb(1'b0, wdog_pkg::OFS_CTRL, 32'h0);
    chk(rdat[4:0], 5'h00);
    wb(1'b0, 8'h1c, 32'h0);
    chk(rdat, 32'h0);
    wb(1'b0, wdog_pkg::OFS_COUNT, 32'h0);
    chk(rdat, 32'h0);
    $display("idle test done");
  endtask : t_idle

  task automatic t_timeout();
    wb(1'b1, wdog_pkg::OFS_TIMEOUT, 32'h4);
    wb(1'b1, wdog_pkg::OFS_MASK, 32'h1);
    wb(1'b1, wdog_pkg::OFS_CTRL, 32'h0d);
    wb(1'b1, wdog_pkg::OFS_CTRL, 32'h02);
    wb(1'b0, wdog_pkg::OFS_CTRL, 32'h0);
    chk(rdat[4:0], 5'h1d);
    repeat (10)
    begin
      wb(1'b1, wdog_pkg::OFS_SERVICE, wdog_pkg::SERVICE_KEY);
      repeat (4) @(posedge clk);
    end
    chk(toutN, 1'b1);
    deep <= 1'b1;
    repeat (60) @(posedge clk);
    deep <= 1'b0;
    light <= 1'b1;
    repeat (60) @(posedge clk);
    light <= 1'b0;
    idle <= 1'b1;
    repeat (60) @(posedge clk);
    idle <= 1'b0;
    chk(toutN, 1'b1);
    wb(1'b1, wdog_pkg::OFS_SERVICE, wdog_pkg::SERVICE_KEY);
    repeat (4) @(posedge clk);
    chk(toutN, 1'b1);
    waitOut();
    chk(toutN, 1'b0);
    chk(rstN, 1'b1);
    @(posedge clk);
    chk(irq, 1'b1);
    wb(1'b1, wdog_pkg::OFS_STATUS, 32'h1);
    chk(irq, 1'b0);
    chk(toutN, 1'b0);
    $display("timeout test done");
  endtask : t_timeout

  task automatic t_resetsel();
    doReset();
    chk(toutN, 1'b1);
    wb(1'b1, wdog_pkg::OFS_TIMEOUT, 32'h4);
    wb(1'b1, wdog_pkg::OFS_WARN, 32'h2);
    wb(1'b1, wdog_pkg::OFS_CTRL, 32'h03);
    wb(1'b1, wdog_pkg::OFS_CTRL, 32'h0f);
    wb(1'b0, wdog_pkg::OFS_CTRL, 32'h0);
    chk(rdat[4:0], 5'h13);
    deep <= 1'b1;
    idle <= 1'b1;
    waitOut();
    deep <= 1'b0;
    idle <= 1'b0;
    chk(rstN, 1'b0);
    chk(toutN, 1'b1);
    wb(1'b0, wdog_pkg::OFS_STATUS, 32'h0);
    chk(rdat, 32'h3);
    chk(irq, 1'b0);
    wb(1'b0, wdog_pkg::OFS_COUNT, 32'h0);
    chk(rdat, 32'h0);
    wb(1'b0, wdog_pkg::OFS_TIMEOUT, 32'h0);
    chk(rdat, 32'h4);
    $display("reset select test done");
  endtask : t_resetsel

  initial
  begin
    @(posedge clk);
    doReset();
    t_idle();
    t_timeout();
    t_resetsel();
    give_verdict();
  end
endmodule : system_watchdog_timer_tb
